//--- src/gpio_defs.svh
// gpio_defs.svh: offsets, reset values and timing counts of the port block
// assumes: included by bare name, by the package and by the main module
`ifndef GPIO_DEFS_SVH
`define GPIO_DEFS_SVH

// pin counts: six 4-bit groups, the first two carry key interrupts
`define KP_NPINS 24
`define KP_NKEY 8

// register byte offsets, one 32-bit word each
`define KP_OFS_DATA 8'h00
`define KP_OFS_DIR 8'h04
`define KP_OFS_PD 8'h08
`define KP_OFS_LVL 8'h0C
`define KP_OFS_KSEL 8'h10
`define KP_OFS_KPOL 8'h14
`define KP_OFS_KFLAG 8'h18
`define KP_OFS_KEN 8'h1C
`define KP_OFS_NRSEL 8'h20
`define KP_OFS_FUNC 8'h24
`define KP_OFS_STAT 8'h28

// field positions
`define KP_NR0_LSB 0
`define KP_NR1_LSB 2
`define KP_STAT_SLEEP 0

// reset values
`define KP_RST_DATA 24'hFFFFFF
`define KP_RST_DIR 24'h000000
`define KP_RST_PD 24'hFFFFFF
`define KP_RST_LVL 8'hFF
`define KP_RST_FUNC 24'h000000
`define KP_RST_KEY 8'h00
`define KP_RST_NR 4'h0

// noise reject widths in microseconds and their clock counts at 100 MHz
`define KP_CLK_MHZ 100
`define KP_NR1_US 500
`define KP_NR2_US 2000
`define KP_NR3_US 7800
`define KP_NR1_CYC (`KP_NR1_US * `KP_CLK_MHZ)
`define KP_NR2_CYC (`KP_NR2_US * `KP_CLK_MHZ)
`define KP_NR3_CYC (`KP_NR3_US * `KP_CLK_MHZ)
`define KP_DIV_W 20

`endif

//--- src/gpio_pkg.sv
// gpio_pkg.sv: types shared by the port block and its noise rejector
// assumes: gpio_defs.svh on the include path
`include "gpio_defs.svh"

package gpio_pkg;
  typedef logic [`KP_NPINS-1:0] pins_t;
  typedef logic [`KP_NKEY-1:0] keys_t;

  // everything that goes to the pad ring
  typedef struct packed {
    pins_t drive;
    pins_t oe;
    pins_t pd_en;
    pins_t schmitt;
  } pad_s;

  // direction and data from peripherals that own a pin
  typedef struct packed {
    pins_t oe;
    pins_t dout;
  } periph_s;

  typedef struct packed {
    logic [3:0] samp;
    logic [3:0] filt;
  } nr_state_s;

  typedef struct packed {
    pins_t                          data;
    pins_t                          dir;
    pins_t                          pd;
    pins_t                          func;
    keys_t                          lvl;
    keys_t                          ksel;
    keys_t                          kpol;
    keys_t                          kflag;
    keys_t                          ken;
    logic [3:0]                     nrsel;
    pins_t                          sync1;
    pins_t                          sync2;
    keys_t                          prev;
    logic                           sleep;
    logic [31:0]                    rdata;
    logic [2:0][`KP_DIV_W-1:0]      div;
  } port_state_s;
endpackage

//--- src/noise_rejector.sv
// noise_rejector.sv: debounce for one 4-bit key group
// assumes: synchronised inputs and one-cycle tick pulses per reject rate
`timescale 1ns/1ps
`default_nettype none

module noise_rejector
(
  // clock and reset
  input  wire logic       ref_clk_in,
  input  wire logic       rst_in,
  // level from the synchroniser, rate select, rate ticks
  input  wire logic [3:0] raw_in,
  input  wire logic [1:0] sel_in,
  input  wire logic [2:0] tick_in,
  // debounced level
  output logic      [3:0] filt_out
);

  gpio_pkg::nr_state_s st_r;
  gpio_pkg::nr_state_s st_nxt;
  logic                tk;

  // a level is taken only when two samples one period apart agree, so a pulse
  // shorter than the period can be seen by at most one sample and is dropped
  always_comb
  begin
    st_nxt = st_r;
    tk = 1'b0;
    unique case (sel_in)
      2'h0: tk = 1'b0;
      2'h1: tk = tick_in[0];
      2'h2: tk = tick_in[1];
      2'h3: tk = tick_in[2];
    endcase
    if (sel_in == 2'h0)
    begin
      st_nxt.samp = raw_in; // bypass: level passes at once
      st_nxt.filt = raw_in;
    end
    else if (tk)
    begin
      st_nxt.samp = raw_in;
      // agreeing samples take the new level, disagreeing ones keep the old
      st_nxt.filt = (st_r.filt & (raw_in ^ st_r.samp)) | (raw_in & ~(raw_in ^ st_r.samp));
    end
  end

  // state register
  always_ff @(posedge ref_clk_in or posedge rst_in)
  begin
    if (rst_in)
      st_r <= '0;
    else
      st_r <= st_nxt;
  end

  assign filt_out = st_r.filt;

endmodule // noise_rejector

`default_nettype wire

//--- src/gpio_key_port.sv
// gpio_key_port.sv: 24-pin general purpose port with key interrupt unit
// assumes: APB master on ref_clk_in, pins and peripheral signals synchronous
// to it, the pad ring resolves drive, enable and pull-down per pin
//
// Functional notes
// - direction 0: pin undriven, used as input.
// - direction 1: pin driven with the output data bit.
// - reading data of an output bit returns the stored data.
// - reset clears all direction bits, every pin starts as input.
// - pin owned by a peripheral: peripheral sets direction, direction bit ignored.
// - key groups: level select 0 plain CMOS, 1 Schmitt, per bit.
// - level select bits reset to Schmitt.
// - groups 2 to 5 always use Schmitt inputs.
// - pull-down only when its bit is 1 and the pin is input.
// - reset sets every pull-down bit to 1.
// - pull-down bit is plain storage without resistor or on output/converter use.
// - peripheral input pins keep normal pull-down and level function.
// - only pins with key select 1 take part in key detection.
// - per-pin polarity picks rising or falling edge.
// - qualifying edge sets factor flag; request raised when enable bit is 1.
// - enable bit 0 suppresses the request for that pin.
// - per-group 2-bit rejector: off, 0.5, 2.0, 7.8 ms reject widths.
// - sleep is left only on a key factor.
// - each pin built push-pull or P-channel open drain.
// - build-time pull-down and drive choice also hold for peripheral use.
// - reset returns every shared pin to port function.
`timescale 1ns/1ps
`default_nettype none
`include "gpio_defs.svh"

module gpio_key_port
#(
  parameter logic [`KP_NPINS-1:0] OD_MASK = 24'h000000, // 1: open drain stage
  parameter logic [`KP_NPINS-1:0] PD_MASK = 24'hFFFFFF, // 1: resistor built in
  parameter logic [`KP_NPINS-1:0] RF_MASK = 24'hF00000, // converter pins
  parameter int unsigned          NR1_CYC = `KP_NR1_CYC,
  parameter int unsigned          NR2_CYC = `KP_NR2_CYC,
  parameter int unsigned          NR3_CYC = `KP_NR3_CYC
)
(
  // clock and reset
  input  wire logic                  ref_clk_in,
  input  wire logic                  rst_in,
  // apb slave
  input  wire logic                  psel_in,
  input  wire logic                  penable_in,
  input  wire logic                  pwrite_in,
  input  wire logic [7:0]            paddr_in,
  input  wire logic [31:0]           pwdata_in,
  output logic      [31:0]           prdata_out,
  output logic                       pready_out,
  output logic                       pslverr_out,
  // pins
  input  wire gpio_pkg::pins_t       pin_in,
  output var  gpio_pkg::pad_s        pad_out,
  // peripherals sharing the pins
  input  wire gpio_pkg::periph_s     periph_in,
  output logic [`KP_NPINS-1:0]       func_sel_out,
  // cpu side
  input  wire logic                  sleep_instr_in,
  output logic                       sleep_out,
  output logic                       key_int_req_out
);

  localparam logic [2:0][`KP_DIV_W-1:0] LIMS = {`KP_DIV_W'(NR3_CYC - 1), `KP_DIV_W'(NR2_CYC - 1),
                                                `KP_DIV_W'(NR1_CYC - 1)};

  // the divider counters are KP_DIV_W bits wide
  if (NR1_CYC < 2 || NR2_CYC < 2 || NR3_CYC < 2 ||
      NR1_CYC > (1 << `KP_DIV_W) || NR2_CYC > (1 << `KP_DIV_W) || NR3_CYC > (1 << `KP_DIV_W))
  begin : g_chk
    $error("reject counts out of range");
  end

  gpio_pkg::port_state_s st_r;
  gpio_pkg::port_state_s st_nxt;
  logic [2:0]            tick;
  gpio_pkg::keys_t       filt;
  gpio_pkg::keys_t       key_evt;
  gpio_pkg::keys_t       clr;
  gpio_pkg::pins_t       outsel;
  gpio_pkg::pins_t       oe_eff;
  gpio_pkg::pins_t       dout_eff;
  logic [31:0]           rmux;
  logic                  hit;

  // debounce per key group, each with its own rate select
  noise_rejector u_nr0
  (
    .ref_clk_in (ref_clk_in),
    .rst_in     (rst_in),
    .raw_in     (st_r.sync2[3:0]),
    .sel_in     (st_r.nrsel[`KP_NR0_LSB +: 2]),
    .tick_in    (tick),
    .filt_out   (filt[3:0])
  );

  noise_rejector u_nr1
  (
    .ref_clk_in (ref_clk_in),
    .rst_in     (rst_in),
    .raw_in     (st_r.sync2[7:4]),
    .sel_in     (st_r.nrsel[`KP_NR1_LSB +: 2]),
    .tick_in    (tick),
    .filt_out   (filt[7:4])
  );

  // effective direction and data: a peripheral-owned pin ignores dir
  assign oe_eff   = (st_r.func & periph_in.oe) | (~st_r.func & st_r.dir);
  assign dout_eff = (st_r.func & periph_in.dout) | (~st_r.func & st_r.data);
  assign outsel   = st_r.dir & ~st_r.func;

  // register read mux and address decode
  always_comb
  begin
    hit = 1'b1;
    rmux = 32'h00000000;
    case (paddr_in)
      `KP_OFS_DATA:  rmux = {8'h00, (st_r.data & outsel) | (st_r.sync2 & ~outsel)};
      `KP_OFS_DIR:   rmux = {8'h00, st_r.dir};
      `KP_OFS_PD:    rmux = {8'h00, st_r.pd};
      `KP_OFS_LVL:   rmux = {24'h000000, st_r.lvl};
      `KP_OFS_KSEL:  rmux = {24'h000000, st_r.ksel};
      `KP_OFS_KPOL:  rmux = {24'h000000, st_r.kpol};
      `KP_OFS_KFLAG: rmux = {24'h000000, st_r.kflag};
      `KP_OFS_KEN:   rmux = {24'h000000, st_r.ken};
      `KP_OFS_NRSEL: rmux = {28'h0000000, st_r.nrsel};
      `KP_OFS_FUNC:  rmux = {8'h00, st_r.func};
      `KP_OFS_STAT:  rmux = {31'h00000000, st_r.sleep};
      default:       hit = 1'b0;
    endcase
  end

  // next state: synchroniser, dividers, key detection, bus writes, sleep
  always_comb
  begin
    st_nxt = st_r;
    clr = 8'h00;
    // first stage feeds only the second stage
    st_nxt.sync1 = pin_in;
    st_nxt.sync2 = st_r.sync1;
    // free-running dividers give one tick per reject period
    for (int i = 0; i < 3; i++)
    begin
      tick[i] = (st_r.div[i] == LIMS[i]);
      st_nxt.div[i] = tick[i] ? '0 : st_r.div[i] + `KP_DIV_W'(1);
    end
    // edge on a debounced level, only on selected pins, polarity per pin
    st_nxt.prev = filt;
    key_evt = st_r.ksel & ((st_r.kpol & filt & ~st_r.prev) | (~st_r.kpol & ~filt & st_r.prev));
    // writes take effect at the access edge
    if (psel_in && penable_in && pwrite_in)
    begin
      case (paddr_in)
        `KP_OFS_DATA:  st_nxt.data  = pwdata_in[23:0];
        `KP_OFS_DIR:   st_nxt.dir   = pwdata_in[23:0];
        `KP_OFS_PD:    st_nxt.pd    = pwdata_in[23:0];
        `KP_OFS_LVL:   st_nxt.lvl   = pwdata_in[7:0];
        `KP_OFS_KSEL:  st_nxt.ksel  = pwdata_in[7:0];
        `KP_OFS_KPOL:  st_nxt.kpol  = pwdata_in[7:0];
        `KP_OFS_KFLAG: clr          = pwdata_in[7:0];
        `KP_OFS_KEN:   st_nxt.ken   = pwdata_in[7:0];
        `KP_OFS_NRSEL: st_nxt.nrsel = pwdata_in[3:0];
        `KP_OFS_FUNC:  st_nxt.func  = pwdata_in[23:0];
        default:       clr          = 8'h00;
      endcase
    end
    // write one clears; a new edge in the same cycle wins over the clear
    st_nxt.kflag = (st_r.kflag & ~clr) | key_evt;
    // read data is caught in the setup phase so prdata comes from a flop
    if (psel_in && !penable_in)
      st_nxt.rdata = rmux;
    // wake wins over a sleep request in the same cycle
    if (key_evt != 8'h00)
      st_nxt.sleep = 1'b0;
    else if (sleep_instr_in)
      st_nxt.sleep = 1'b1;
  end

  // state register with documented defaults
  always_ff @(posedge ref_clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      st_r       <= '0;
      st_r.data  <= `KP_RST_DATA;
      st_r.dir   <= `KP_RST_DIR;
      st_r.pd    <= `KP_RST_PD;
      st_r.lvl   <= `KP_RST_LVL;
      st_r.func  <= `KP_RST_FUNC;
      st_r.ksel  <= `KP_RST_KEY;
      st_r.kflag <= `KP_RST_KEY;
      st_r.ken   <= `KP_RST_KEY;
      st_r.nrsel <= `KP_RST_NR;
    end
    else
      st_r <= st_nxt;
  end

  // pad controls; open drain pins only drive high, the stage choice and the
  // resistor choice hold whoever owns the pin
  always_comb
  begin
    pad_out.drive   = dout_eff;
    pad_out.oe      = oe_eff & (~OD_MASK | dout_eff);
    pad_out.pd_en   = st_r.pd & PD_MASK & ~oe_eff & ~(st_r.func & RF_MASK);
    pad_out.schmitt = {16'hFFFF, st_r.lvl};
  end

  // bus answer: no wait states, unmapped addresses flag an error
  assign pready_out      = 1'b1;
  assign pslverr_out     = psel_in & penable_in & ~hit;
  assign prdata_out      = st_r.rdata;
  assign func_sel_out    = st_r.func;
  assign sleep_out       = st_r.sleep;
  assign key_int_req_out = |(st_r.kflag & st_r.ken);

  // checks
  default clocking cb @(posedge ref_clk_in);
  endclocking
  default disable iff (rst_in);

  a_input_hiz: assert property ((pad_out.oe & ~st_r.func & ~st_r.dir) == '0)
    else $error("input pin is driven");
  a_output_drive: assert property (((~pad_out.oe | (pad_out.drive ^ st_r.data)) & outsel & ~OD_MASK) == '0)
    else $error("output pin not driven with data");
  a_read_outdata: assert property ((psel_in && penable_in && !pwrite_in && paddr_in == `KP_OFS_DATA)
    |-> ((prdata_out[23:0] ^ st_r.data) & outsel) == '0)
    else $error("output bit read back not from data");
  a_periph_owns: assert property ((st_r.func & (pad_out.oe ^ (periph_in.oe & (~OD_MASK | periph_in.dout)))) == '0)
    else $error("peripheral pin direction wrong");
  a_pd_gate: assert property ((pad_out.pd_en & (oe_eff | ~st_r.pd | ~PD_MASK)) == '0)
    else $error("pull-down active when it must not be");
  a_level_fixed: assert property (pad_out.schmitt[23:8] == 16'hFFFF)
    else $error("fixed group not schmitt");
  a_flag_set: assert property ((key_evt != 8'h00) |=> ((st_r.kflag & $past(key_evt)) == $past(key_evt)))
    else $error("factor flag not set on edge");
  a_irq_raise: assert property (((key_evt & st_r.ken) != 8'h00) |=> key_int_req_out)
    else $error("request not raised");
  a_irq_mask: assert property ((st_r.ken == 8'h00) |-> !key_int_req_out)
    else $error("masked request raised");
  a_wake_cause: assert property ($fell(st_r.sleep) |-> ($past(key_evt) != 8'h00))
    else $error("sleep left without key factor");

  c_key_edge: cover property (key_evt != 8'h00);
  c_sleep_wake: cover property (st_r.sleep ##1 !st_r.sleep);
  c_irq: cover property ($rose(key_int_req_out));
  c_read: cover property (psel_in && penable_in && !pwrite_in && hit);

endmodule // gpio_key_port

`default_nettype wire

//--- dv/pin_model.sv
// pin_model.sv: keys, switches and pulls seen on the port pins
// assumes: pad controls from gpio_key_port, key levels and key activity from the bench
`timescale 1ns/1ps
`default_nettype none

module pin_model
(
  // pad controls and key levels
  input  wire gpio_pkg::pad_s  pad_in,
  input  wire gpio_pkg::pins_t key_in,
  input  wire gpio_pkg::pins_t key_on_in,
  // level seen on each pin
  output var  gpio_pkg::pins_t pin_out
);
  gpio_pkg::pins_t held;
  gpio_pkg::pins_t drv;
  gpio_pkg::pins_t lvl;

  // port drive beats a key, a key beats the pull-down
  always_comb
  begin
    drv = pad_in.oe | key_on_in | pad_in.pd_en;
    lvl = (pad_in.oe & pad_in.drive) | (~pad_in.oe & key_on_in & key_in);
  end

  // a floating pin shows the inverse of its last level, so a stale value never reads as valid
  always @(drv or lvl)
  begin
    held = (held & ~drv) | (lvl & drv);
  end
  assign pin_out = (drv & lvl) | (~drv & ~held);
endmodule // pin_model

`default_nettype wire

//--- dv/test_io_port_key_interrupt.sv
// test_io_port_key_interrupt.sv: self-checking bench for gpio_key_port
// assumes: pin_model on the pins, short reject counts 4/8/16 cycles
`timescale 1ns/1ps
`default_nettype none
`include "gpio_defs.svh"

module test_io_port_key_interrupt;
  localparam int NR [1:3] = '{4, 8, 16};
  logic              ref_clk = 1'b0;
  logic              rst = 1'b1;
  logic              psel = 1'b0;
  logic              penable = 1'b0;
  logic              pwrite = 1'b0;
  logic [7:0]        paddr = 8'h00;
  logic [31:0]       pwdata = 32'h0;
  logic [31:0]       prdata;
  logic              pready;
  logic              pslverr;
  gpio_pkg::pins_t   pin;
  gpio_pkg::pad_s    pad;
  gpio_pkg::periph_s periph = '0;
  gpio_pkg::pins_t   key = 24'h00000B;
  gpio_pkg::pins_t   key_on = 24'hFFFFFF;
  logic [23:0]       func_sel;
  logic              sleep_instr = 1'b0;
  logic              sleep_o;
  logic              req;
  int                n_mismatch = 0;
  int                checks_done = 0;
  logic [31:0]       rd;
  logic              err;

  // device under test with short reject counts
  gpio_key_port #(.OD_MASK(24'h000001), .PD_MASK(24'hFFFFFD), .NR1_CYC(4), .NR2_CYC(8), .NR3_CYC(16)) i_dut
  (.ref_clk_in(ref_clk), .rst_in(rst), .psel_in(psel), .penable_in(penable), .pwrite_in(pwrite),
   .paddr_in(paddr), .pwdata_in(pwdata), .prdata_out(prdata), .pready_out(pready), .pslverr_out(pslverr),
   .pin_in(pin), .pad_out(pad), .periph_in(periph), .func_sel_out(func_sel),
   .sleep_instr_in(sleep_instr), .sleep_out(sleep_o), .key_int_req_out(req));

  // keys on the far side
  pin_model i_pins (.pad_in(pad), .key_in(key), .key_on_in(key_on), .pin_out(pin));

  // 100 MHz clock
  always #5 ref_clk = ~ref_clk;

  task automatic complete_run();
    if (n_mismatch == 0 && checks_done > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp)
    begin
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
      n_mismatch++;
    end
  endtask

  // one apb transfer; waits for pready under a bound, ends 1 ns after the edge so outputs settle
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge ref_clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge ref_clk);
    penable <= 1'b1;
    @(posedge ref_clk);
    while (pready !== 1'b1 && n < 100)
    begin
      n++;
      @(posedge ref_clk);
    end
    if (n >= 100)
    begin
      $display("[ERR] %0t no pready", $time);
      n_mismatch++;
      complete_run();
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    #1;
  endtask

  task automatic rchk(input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(rd, exp);
  endtask

  // main sequence
  initial
  begin
    repeat (20) @(posedge ref_clk);
    rst <= 1'b0;
    rchk(`KP_OFS_DIR, 32'h0);
    rchk(`KP_OFS_PD, 32'h00FFFFFF);
    rchk(`KP_OFS_LVL, 32'h000000FF);
    rchk(`KP_OFS_FUNC, 32'h0);
    chk(32'(pad.oe), 32'h0);
    chk(32'(pad.schmitt), 32'h00FFFFFF);
    chk(32'(pad.pd_en), 32'h00FFFFFD);
    apb(1'b0, 8'hFC, 32'h0);
    chk({31'h0, err}, 32'h1);
    // outputs; open-drain bit 0 stays undriven at 0 while its key pulls high
    apb(1'b1, `KP_OFS_DATA, 32'h00A5C35A);
    apb(1'b1, `KP_OFS_DIR, 32'h00FFFFFF);
    chk(32'(pad.oe), 32'h00FFFFFE);
    chk(32'(pad.drive & pad.oe), 32'h00A5C35A);
    chk(32'(pad.pd_en), 32'h0);
    rchk(`KP_OFS_DATA, 32'h00A5C35A);
    // level select on key groups only
    apb(1'b1, `KP_OFS_LVL, 32'h0);
    chk(32'(pad.schmitt), 32'h00FFFF00);
    apb(1'b1, `KP_OFS_LVL, 32'h000000FF);
    // peripherals own every pin while the direction bits say output
    periph.oe <= 24'h0F0F0E;
    apb(1'b1, `KP_OFS_FUNC, 32'h00FFFFFF);
    chk(32'(func_sel), 32'h00FFFFFF);
    chk(32'(pad.oe), 32'h000F0F0E);
    chk(32'(pad.pd_en), 32'h0000F0F1);
    apb(1'b1, `KP_OFS_FUNC, 32'h0);
    apb(1'b1, `KP_OFS_DIR, 32'h0);
    apb(1'b1, `KP_OFS_PD, 32'h000F0F0F);
    chk(32'(pad.pd_en), 32'h000F0F0D);
    // key table: pin, new level, flags, request
    @(posedge ref_clk);
    key[0] <= 1'b0;
    apb(1'b1, `KP_OFS_KSEL, 32'h1F);
    apb(1'b1, `KP_OFS_KPOL, 32'h15);
    apb(1'b1, `KP_OFS_KEN, 32'h03);
    apb(1'b1, `KP_OFS_KFLAG, 32'hFF);
    for (int s = 0; s < 6; s++)
    begin
      int b;
      logic v;
      logic [7:0] f;
      logic q;
      {b, v, f, q} = (s == 0) ? {32'd0, 1'b1, 8'h01, 1'b1} : (s == 1) ? {32'd1, 1'b0, 8'h02, 1'b1} :
                     (s == 2) ? {32'd0, 1'b0, 8'h00, 1'b0} : (s == 3) ? {32'd2, 1'b1, 8'h04, 1'b0} :
                     (s == 4) ? {32'd5, 1'b1, 8'h00, 1'b0} : {32'd3, 1'b0, 8'h08, 1'b0};
      @(posedge ref_clk);
      key[b] <= v;
      repeat (8) @(posedge ref_clk);
      rchk(`KP_OFS_KFLAG, {24'h0, f});
      chk({31'h0, req}, {31'h0, q});
      apb(1'b1, `KP_OFS_KFLAG, 32'hFF);
      chk({31'h0, req}, 32'h0);
    end
    // each reject width on both groups: a short pulse is lost, a long one is taken
    for (int g = 0; g < 2; g++)
    begin
      for (int c = 1; c <= 3; c++)
      begin
        apb(1'b1, `KP_OFS_NRSEL, 32'(c << (2 * g)));
        for (int w = 0; w < 2; w++)
        begin
          @(posedge ref_clk);
          key[4 * g] <= 1'b1;
          repeat (w ? 3 * NR[c] : NR[c] / 2) @(posedge ref_clk);
          key[4 * g] <= 1'b0;
          repeat (3 * NR[c] + 8) @(posedge ref_clk);
          rchk(`KP_OFS_KFLAG, 32'(w << (4 * g)));
          apb(1'b1, `KP_OFS_KFLAG, 32'hFF);
        end
      end
    end
    // sleep: rejector bypassed, select and enable set first
    apb(1'b1, `KP_OFS_NRSEL, 32'h0);
    @(posedge ref_clk);
    sleep_instr <= 1'b1;
    @(posedge ref_clk);
    sleep_instr <= 1'b0;
    key[5] <= 1'b0;
    repeat (8) @(posedge ref_clk);
    #1;
    chk({31'h0, sleep_o}, 32'h1);
    rchk(`KP_OFS_STAT, 32'h1);
    @(posedge ref_clk);
    key[0] <= 1'b1;
    repeat (8) @(posedge ref_clk);
    #1;
    chk({31'h0, sleep_o}, 32'h0);
    chk({31'h0, req}, 32'h1);
    complete_run();
  end
endmodule // test_io_port_key_interrupt

`default_nettype wire
